// >>> verification/adfpt_dram_model.sv
`timescale 1ns/1ns
module adfpt_dram_model import adfpt_pkg::*; (
    // Memory pins
    input wire adfpt_pins_t i_dram,
    output logic o_sample_out_bit,
    // Observation counters
    output int o_refreshes,
    output int o_ras_falls,
    output int o_viol
);
    logic mem [bit [19:0]];
    logic [9:0] row_ff;
    logic [19:0] cur_addr;
    logic q_ff;
    logic drive_ff;
    time t_ras_fall;
    time t_ras_rise;
    time t_cas_fall;
    time t_cas_rise;
    time t_we_fall;

    initial begin
        o_refreshes = 0;
        o_ras_falls = 0;
        o_viol = 0;
        q_ff = 1'b0;
        drive_ff = 1'b0;
        row_ff = 10'h000;
        cur_addr = 20'h00000;
    end

    // Released line shows the inverse of its last driven value
    assign o_sample_out_bit = drive_ff ? q_ff : ~q_ff;

    always @(negedge i_dram.row_strobe_n) begin
        if (o_ras_falls > 0 && $time - t_ras_fall < T_RC_NS) o_viol++;
        if (o_ras_falls > 0 && $time - t_ras_rise < T_RP_NS) o_viol++;
        o_ras_falls++;
        t_ras_fall = $time;
        if (i_dram.column_strobe_n === 1'b0) begin
            if ($time - t_cas_fall < T_CSR_NS) o_viol++;
            o_refreshes++;
        end else begin
            row_ff = i_dram.mux_addr_bus;
        end
    end

    always @(posedge i_dram.row_strobe_n) begin
        if (o_ras_falls > 0 && $time - t_ras_fall < T_RAS_MIN_NS) o_viol++;
        if (o_ras_falls > 0 && $time - t_ras_fall > T_RAS_MAX_NS) o_viol++;
        t_ras_rise = $time;
    end

    always @(negedge i_dram.column_strobe_n) begin
        t_cas_fall = $time;
        if (i_dram.row_strobe_n === 1'b0) begin
            if ($time - t_cas_rise < T_CP_NS) o_viol++;
            cur_addr = {row_ff, i_dram.mux_addr_bus};
            if (i_dram.write_enable_n === 1'b0) begin
                mem[cur_addr] = i_dram.sample_in_bit;
            end else begin
                q_ff <= #T_CAC_NS (mem.exists(cur_addr) ? mem[cur_addr] : 1'b0);
                drive_ff <= #T_CAC_NS 1'b1;
            end
        end
    end

    always @(negedge i_dram.write_enable_n) begin
        t_we_fall = $time;
        if (i_dram.column_strobe_n === 1'b0 && i_dram.row_strobe_n === 1'b0) begin
            mem[cur_addr] = i_dram.sample_in_bit;
            if (!drive_ff) q_ff <= 1'bx;
        end
    end

    always @(posedge i_dram.write_enable_n) begin
        if ($time - t_we_fall < T_WP_NS) o_viol++;
    end

    always @(posedge i_dram.column_strobe_n) begin
        t_cas_rise = $time;
        drive_ff <= 1'b0;
    end
endmodule

// >>> verification/async_dram_fast_page_timing_test.sv
`timescale 1ns/1ns
module async_dram_fast_page_timing_test;
    import adfpt_pkg::*;
    localparam int REF_CYC = 51200;
    logic i_clk;
    logic i_sys_rst;
    logic i_ce;
    logic i_req_valid;
    adfpt_req_t i_req;
    logic o_req_ready;
    logic o_rd_valid;
    logic o_rd_data;
    logic o_init_done;
    logic sample_out_bit;
    adfpt_pins_t o_dram;
    adfpt_pins_t pins;
    int n_mismatch;
    int n_tests;
    int refreshes;
    int ras_falls;
    int viol;
    int seed;
    int r0;
    int f0;
    logic exp_q[$];
    logic shadow [bit [19:0]];
    logic [19:0] addr [12];
    logic dat [12];
    logic [9:0] row;

    adfpt_host_ctrl #(.REF_PERIOD_CYC(REF_CYC)) uut (
        .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_ce(i_ce),
        .i_req_valid(i_req_valid), .i_req(i_req), .o_req_ready(o_req_ready),
        .o_rd_valid(o_rd_valid), .o_rd_data(o_rd_data), .o_init_done(o_init_done),
        .o_dram(o_dram), .i_sample_out_bit(sample_out_bit)
    );

    adfpt_dram_model model (
        .i_dram(o_dram), .o_sample_out_bit(sample_out_bit),
        .o_refreshes(refreshes), .o_ras_falls(ras_falls), .o_viol(viol)
    );

    initial begin
        i_clk = 1'b0;
        forever #20 i_clk = ~i_clk;
    end

    task automatic results();
        if (n_mismatch == 0 && n_tests > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic check_bit(input string what, input logic exp, input logic got);
        n_tests++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %b seen %b", what, exp, got);
        end
    endtask

    task automatic check_pins(input string what, input adfpt_pins_t exp, input adfpt_pins_t got);
        n_tests++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic do_req(input logic [19:0] a, input logic wr, input logic rmw, input logic wd);
        int k;
        @(posedge i_clk);
        i_req <= '{addr: a, write: wr, rmw: rmw, wdata: wd};
        i_req_valid <= 1'b1;
        if (!wr || rmw) exp_q.push_back(shadow.exists(a) ? shadow[a] : 1'b0);
        if (wr || rmw) shadow[a] = wd;
        for (k = 0; k < 4000; k++) begin
            @(negedge i_clk);
            if (o_req_ready === 1'b1) break;
        end
        if (k == 4000) begin
            n_mismatch++;
            results();
        end
        @(posedge i_clk);
        i_req_valid <= 1'b0;
    endtask

    task automatic wait_init();
        int k;
        for (k = 0; k < 4000; k++) begin
            @(negedge i_clk);
            if (o_init_done === 1'b1) break;
        end
        if (k == 4000) begin
            n_mismatch++;
            results();
        end
    endtask

    task automatic reset_check();
        int k;
        for (k = 0; k < 200; k++) begin
            @(negedge i_clk);
            if (o_dram.row_strobe_n === 1'b1 && o_dram.column_strobe_n === 1'b1) break;
        end
        if (k == 200) begin
            n_mismatch++;
            results();
        end
        @(posedge i_clk);
        i_sys_rst <= 1'b1;
        repeat (2) @(posedge i_clk);
        @(negedge i_clk);
        check_pins("reset pins", PINS_RESET, o_dram);
        check_bit("reset init_done", 1'b0, o_init_done);
        check_bit("reset ready", 1'b0, o_req_ready);
        @(posedge i_clk);
        i_sys_rst <= 1'b0;
        r0 = ras_falls;
        f0 = refreshes;
        repeat (C_PWR - 20) @(posedge i_clk);
        check_bit("row strobe in pause", 1'b1, ras_falls == r0);
        wait_init();
        check_bit("wake cycles", 1'b1, ras_falls - r0 >= WAKE_CYCLES);
        check_bit("wake kind", 1'b1, refreshes - f0 == ras_falls - r0);
    endtask

    always @(negedge i_clk) begin
        if (o_rd_valid === 1'b1) begin
            check_bit("rd_valid expected", 1'b1, exp_q.size() > 0);
            if (exp_q.size() > 0) check_bit("rd_data", exp_q.pop_front(), o_rd_data);
        end
    end

    initial begin
        seed = 32'h84b3;
        n_mismatch = 0;
        n_tests = 0;
        i_sys_rst = 1'b1;
        i_ce = 1'b1;
        i_req_valid = 1'b0;
        i_req = '0;
        reset_check();
        for (int i = 0; i < 12; i++) begin
            addr[i] = 20'($random(seed));
            dat[i] = 1'($random(seed));
            do_req(addr[i], 1'b1, 1'b0, dat[i]);
        end
        for (int i = 11; i >= 0; i--) do_req(addr[i], 1'b0, 1'b0, 1'b0);
        row = 10'($random(seed));
        for (int j = 0; j < 8; j++) do_req({row, 10'(j)}, 1'b1, 1'b0, j[0] ^ j[1]);
        for (int j = 0; j < 8; j++) do_req({row, 10'(j)}, 1'b0, 1'b0, 1'b0);
        for (int i = 0; i < 4; i++) begin
            do_req(addr[i], 1'b0, 1'b1, ~dat[i]);
            do_req(addr[i], 1'b0, 1'b0, 1'b0);
        end
        repeat (30) @(posedge i_clk);
        i_ce <= 1'b0;
        @(negedge i_clk);
        pins = o_dram;
        repeat (6) @(posedge i_clk);
        @(negedge i_clk);
        check_pins("pins while frozen", pins, o_dram);
        @(posedge i_clk);
        i_ce <= 1'b1;
        r0 = refreshes;
        repeat (REF_CYC / REF_ROWS * 50) @(posedge i_clk);
        check_bit("refresh rate low", 1'b1, refreshes - r0 >= 45);
        check_bit("refresh rate high", 1'b1, refreshes - r0 <= 55);
        reset_check();
        do_req(addr[5], 1'b0, 1'b0, 1'b0);
        repeat (20) @(posedge i_clk);
        check_bit("reads all returned", 1'b1, exp_q.size() == 0);
        check_bit("strobe timing", 1'b1, viol == 0);
        results();
    end
endmodule

// >>> verilog/adfpt_host_ctrl.sv
`timescale 1ns/1ns
module adfpt_host_ctrl import adfpt_pkg::*; #(
    parameter int REF_PERIOD_CYC = C_REF_PERIOD
) (
    // Clock and control
    input wire logic i_clk,
    input wire logic i_sys_rst,
    input wire logic i_ce,
    // Access requests
    input wire logic i_req_valid,
    input wire adfpt_req_t i_req,
    output logic o_req_ready,
    // Read return
    output logic o_rd_valid,
    output logic o_rd_data,
    // Status
    output logic o_init_done,
    // Memory pins
    output adfpt_pins_t o_dram,
    input wire logic i_sample_out_bit
);

    localparam int REF_INT_CYC = REF_PERIOD_CYC / REF_ROWS;

    adfpt_state_t state_ff;
    adfpt_state_t nxt_state;
    adfpt_pins_t pins_ff;
    adfpt_req_t req_ff;
    logic [WAIT_W-1:0] wait_ff;
    logic [WAIT_W-1:0] ras_open_ff;
    logic [WAKE_W-1:0] wake_left_ff;
    logic ready_ff;
    logic nxt_ready;
    logic have_req_ff;
    logic ref_pend_ff;
    logic rd_valid_ff;
    logic rd_data_ff;
    logic init_done_ff;
    logic ref_tick;
    logic ref_overdue;
    logic accept;
    logic ref_busy;
    logic row_hit;
    logic near_max;
    logic first_xfer;
    logic ref_done;

    function automatic logic [ROW_W-1:0] row_of(input logic [ADDR_W-1:0] a);
        return a[ADDR_W-1:COL_W];
    endfunction

    assign accept = i_req_valid && ready_ff;
    assign ref_busy = ref_pend_ff || (wake_left_ff != '0);
    assign row_hit = row_of(i_req.addr) == row_of(req_ff.addr);
    assign near_max = ras_open_ff >= WAIT_W'(C_RAS_MAX - C_PAGE_ACC);
    assign first_xfer = req_ff.rmw ? (wait_ff == WAIT_W'(C_WP)) : 1'b1;
    assign ref_done = (state_ff == ST_REF_RAS) && (wait_ff == '0);

    // Sequencer
    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            ST_PWRUP: begin
                if (wait_ff == '0) begin
                    nxt_state = ST_IDLE;
                end
            end
            ST_IDLE: begin
                if (accept) begin
                    nxt_state = ST_RAS;
                end else if (ref_busy) begin
                    nxt_state = ST_REF_CAS;
                end
            end
            ST_RAS: nxt_state = ST_COL;
            ST_COL: nxt_state = ST_CAS;
            ST_CAS: nxt_state = ST_XFER;
            ST_XFER: begin
                if (wait_ff == '0) begin
                    nxt_state = ST_PAGE;
                end
            end
            ST_PAGE: begin
                if (accept && row_hit) begin
                    nxt_state = ST_COL;
                end else begin
                    nxt_state = ST_PRE;
                end
            end
            ST_PRE: begin
                if (wait_ff == '0) begin
                    nxt_state = have_req_ff ? ST_RAS : ST_IDLE;
                end
            end
            ST_REF_CAS: nxt_state = ST_REF_RAS;
            ST_REF_RAS: begin
                if (wait_ff == '0) begin
                    nxt_state = ST_PRE;
                end
            end
            default: nxt_state = ST_IDLE;
        endcase
    end

    always_comb begin
        nxt_ready = 1'b0;
        if (!ref_busy) begin
            nxt_ready = (nxt_state == ST_IDLE) || ((nxt_state == ST_PAGE) && !near_max);
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            state_ff <= ST_PWRUP;
            ready_ff <= 1'b0;
        end else if (i_ce) begin
            state_ff <= nxt_state;
            ready_ff <= nxt_ready;
        end
    end

    // Step timer
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            wait_ff <= WAIT_W'(C_PWR - 1);
        end else if (i_ce) begin
            if (nxt_state != state_ff && nxt_state == ST_PRE) begin
                wait_ff <= WAIT_W'(C_RP - 1);
            end else if (nxt_state != state_ff && nxt_state == ST_REF_RAS) begin
                wait_ff <= WAIT_W'(C_RAS_MIN - 1);
            end else if (nxt_state != state_ff && nxt_state == ST_XFER) begin
                wait_ff <= req_ff.rmw ? WAIT_W'(C_WP) : '0;
            end else if (wait_ff != '0) begin
                wait_ff <= wait_ff - 1'b1;
            end
        end
    end

    // Request latch
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            req_ff <= '0;
            have_req_ff <= 1'b0;
        end else if (i_ce) begin
            if (accept) begin
                req_ff <= i_req;
            end
            if (accept && state_ff == ST_PAGE && !row_hit) begin
                have_req_ff <= 1'b1;
            end else if (state_ff == ST_PRE && nxt_state == ST_RAS) begin
                have_req_ff <= 1'b0;
            end
        end
    end

    // Pin drive
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            pins_ff <= PINS_RESET;
        end else if (i_ce) begin
            case (state_ff)
                ST_IDLE: begin
                    if (accept) begin
                        pins_ff.mux_addr_bus <= row_of(i_req.addr);
                    end else if (ref_busy) begin
                        pins_ff.column_strobe_n <= 1'b0;
                    end
                end
                ST_RAS: pins_ff.row_strobe_n <= 1'b0;
                ST_COL: begin
                    pins_ff.mux_addr_bus <= req_ff.addr[COL_W-1:0];
                    pins_ff.write_enable_n <= !(req_ff.write && !req_ff.rmw);
                    pins_ff.sample_in_bit <= req_ff.wdata;
                end
                ST_CAS: pins_ff.column_strobe_n <= 1'b0;
                ST_XFER: begin
                    if (first_xfer && req_ff.rmw) begin
                        pins_ff.write_enable_n <= 1'b0;
                    end
                    if (wait_ff == '0) begin
                        pins_ff.column_strobe_n <= 1'b1;
                        pins_ff.write_enable_n <= 1'b1;
                    end
                end
                ST_PAGE: begin
                    if (!(accept && row_hit)) begin
                        pins_ff.row_strobe_n <= 1'b1;
                    end
                end
                ST_PRE: begin
                    if (wait_ff == '0 && have_req_ff) begin
                        pins_ff.mux_addr_bus <= row_of(req_ff.addr);
                    end
                end
                ST_REF_CAS: pins_ff.row_strobe_n <= 1'b0;
                ST_REF_RAS: begin
                    if (wait_ff == '0) begin
                        pins_ff.row_strobe_n <= 1'b1;
                        pins_ff.column_strobe_n <= 1'b1;
                    end
                end
                default: pins_ff <= pins_ff;
            endcase
        end
    end

    // Read capture while column strobe is low
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            rd_valid_ff <= 1'b0;
            rd_data_ff <= 1'b0;
        end else if (i_ce) begin
            rd_valid_ff <= 1'b0;
            if (state_ff == ST_XFER && first_xfer && (!req_ff.write || req_ff.rmw)) begin
                rd_valid_ff <= 1'b1;
                rd_data_ff <= i_sample_out_bit;
            end
        end
    end

    // Row-open time
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            ras_open_ff <= '0;
        end else if (i_ce) begin
            if (!pins_ff.row_strobe_n) begin
                ras_open_ff <= ras_open_ff + 1'b1;
            end else begin
                ras_open_ff <= '0;
            end
        end
    end

    // Refresh scheduling
    adfpt_interval_timer #(
        .PERIOD(REF_INT_CYC)
    ) u_ref_tick (
        .i_clk(i_clk),
        .i_sys_rst(i_sys_rst),
        .i_ce(i_ce),
        .i_restart(1'b0),
        .o_expired(ref_tick)
    );

    adfpt_interval_timer #(
        .PERIOD(REF_PERIOD_CYC)
    ) u_ref_watchdog (
        .i_clk(i_clk),
        .i_sys_rst(i_sys_rst),
        .i_ce(i_ce),
        .i_restart(ref_done),
        .o_expired(ref_overdue)
    );

    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            ref_pend_ff <= 1'b0;
            wake_left_ff <= WAKE_W'(WAKE_CYCLES);
            init_done_ff <= 1'b0;
        end else if (i_ce) begin
            if (ref_tick) begin
                ref_pend_ff <= 1'b1;
            end else if (ref_done) begin
                ref_pend_ff <= 1'b0;
            end
            if (ref_overdue) begin
                wake_left_ff <= WAKE_W'(WAKE_CYCLES);
            end else if (ref_done && wake_left_ff != '0) begin
                wake_left_ff <= wake_left_ff - 1'b1;
            end
            init_done_ff <= (state_ff != ST_PWRUP) && (wake_left_ff == '0);
        end
    end

    assign o_dram = pins_ff;
    assign o_req_ready = ready_ff;
    assign o_rd_valid = rd_valid_ff;
    assign o_rd_data = rd_data_ff;
    assign o_init_done = init_done_ff;

    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (i_sys_rst);

    property p_ras_min;
        $rose(o_dram.row_strobe_n) |-> ras_open_ff >= C_RAS_MIN;
    endproperty
    a_ras_min: assert property (p_ras_min) else $error("row strobe low too short");

    property p_ras_max;
        ras_open_ff <= C_RAS_MAX;
    endproperty
    a_ras_max: assert property (p_ras_max) else $error("row strobe low too long");

    property p_precharge;
        $rose(o_dram.row_strobe_n) |-> o_dram.row_strobe_n [*2];
    endproperty
    a_precharge: assert property (p_precharge) else $error("row precharge too short");

    property p_cas_pre;
        $rose(o_dram.column_strobe_n) |=> o_dram.column_strobe_n;
    endproperty
    a_cas_pre: assert property (p_cas_pre) else $error("column precharge too short");

    property p_early_write;
        $fell(o_dram.column_strobe_n) && !o_dram.row_strobe_n && req_ff.write && !req_ff.rmw
            |-> !o_dram.write_enable_n && $past(!o_dram.write_enable_n);
    endproperty
    a_early_write: assert property (p_early_write) else $error("early write enable late");

    property p_rmw_late;
        $fell(o_dram.write_enable_n) && !o_dram.column_strobe_n
            |-> $past(!o_dram.column_strobe_n) && ras_open_ff >= C_RAS_MIN;
    endproperty
    a_rmw_late: assert property (p_rmw_late) else $error("read-write enable too early");

    property p_we_width;
        !o_dram.write_enable_n && !o_dram.column_strobe_n |=> !o_dram.write_enable_n || o_dram.column_strobe_n;
    endproperty
    a_we_width: assert property (p_we_width) else $error("write enable released early");

    property p_cbr;
        $fell(o_dram.row_strobe_n) && !o_dram.column_strobe_n
            |-> $past(!o_dram.column_strobe_n) ##1 !o_dram.column_strobe_n;
    endproperty
    a_cbr: assert property (p_cbr) else $error("refresh strobe order broken");

    property p_sample;
        o_rd_valid |-> $past(!o_dram.column_strobe_n) && $past(o_dram.column_strobe_n, 2);
    endproperty
    a_sample: assert property (p_sample) else $error("read sampled at wrong time");

    property p_row_setup;
        $fell(o_dram.row_strobe_n) && o_dram.column_strobe_n |-> $stable(o_dram.mux_addr_bus);
    endproperty
    a_row_setup: assert property (p_row_setup) else $error("row address not set up");

    c_page_hit: cover property (state_ff == ST_PAGE ##1 state_ff == ST_COL);
    c_rmw: cover property (o_rd_valid && req_ff.rmw);
    c_refresh: cover property (ref_done && init_done_ff);
    c_init: cover property ($rose(init_done_ff));

endmodule

// >>> verilog/adfpt_interval_timer.sv
`timescale 1ns/1ns
module adfpt_interval_timer #(
    parameter int PERIOD = 390,
    parameter int W = $clog2(PERIOD + 1)
) (
    // Clock and control
    input wire logic i_clk,
    input wire logic i_sys_rst,
    input wire logic i_ce,
    // Restart the interval
    input wire logic i_restart,
    // One-cycle pulse at the end of each interval
    output logic o_expired
);

    logic [W-1:0] count_ff;
    logic expired_ff;

    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            count_ff <= '0;
            expired_ff <= 1'b0;
        end else if (i_ce) begin
            expired_ff <= 1'b0;
            if (i_restart) begin
                count_ff <= '0;
            end else if (count_ff == W'(PERIOD - 1)) begin
                count_ff <= '0;
                expired_ff <= 1'b1;
            end else begin
                count_ff <= count_ff + 1'b1;
            end
        end
    end

    assign o_expired = expired_ff;

endmodule

// >>> verilog/adfpt_pkg.sv
package adfpt_pkg;

    // Clock period of the controller
    localparam int CLK_NS = 40;

    function automatic int cyc_min(input int ns);
        int c;
        c = (ns + CLK_NS - 1) / CLK_NS;
        return (c < 1) ? 1 : c;
    endfunction

    function automatic int cyc_max(input int ns);
        int c;
        c = ns / CLK_NS;
        return (c < 1) ? 1 : c;
    endfunction

    // Device timing, fastest grade, in ns unless named otherwise
    localparam int T_RC_NS = 130;
    localparam int T_PC_NS = 40;
    localparam int T_PRWC_NS = 65;
    localparam int T_RAS_MIN_NS = 70;
    localparam int T_RAS_MAX_NS = 100000;
    localparam int T_RP_NS = 50;
    localparam int T_CP_NS = 10;
    localparam int T_CAC_NS = 20;
    localparam int T_WP_NS = 15;
    localparam int T_CSR_NS = 10;
    localparam int T_PWR_US = 100;
    localparam int T_REF_MS = 8;
    localparam int REF_ROWS = 512;
    localparam int WAKE_CYCLES = 8;

    // Derived cycle counts
    localparam int C_RC = cyc_min(T_RC_NS);
    localparam int C_RAS_MIN = cyc_min(T_RAS_MIN_NS);
    localparam int C_RAS_MAX = cyc_max(T_RAS_MAX_NS);
    localparam int C_RP = cyc_min(T_RP_NS);
    localparam int C_CP = cyc_min(T_CP_NS);
    localparam int C_CAC = cyc_min(T_CAC_NS);
    localparam int C_WP = cyc_min(T_WP_NS);
    localparam int C_CSR = cyc_min(T_CSR_NS);
    localparam int C_PWR = cyc_min(T_PWR_US * 1000);
    localparam int C_REF_PERIOD = cyc_max(T_REF_MS * 1000000);
    // Cycles one page column access keeps the row open
    localparam int C_PAGE_ACC = 5;

    // Field layout
    localparam int ROW_W = 10;
    localparam int COL_W = 10;
    localparam int ADDR_W = ROW_W + COL_W;
    localparam int WAIT_W = 12;
    localparam int WAKE_W = 4;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic write;
        logic rmw;
        logic wdata;
    } adfpt_req_t;

    typedef struct packed {
        logic row_strobe_n;
        logic column_strobe_n;
        logic write_enable_n;
        logic [ROW_W-1:0] mux_addr_bus;
        logic sample_in_bit;
    } adfpt_pins_t;

    localparam adfpt_pins_t PINS_RESET = '{
        row_strobe_n: 1'b1,
        column_strobe_n: 1'b1,
        write_enable_n: 1'b1,
        mux_addr_bus: 10'h000,
        sample_in_bit: 1'b0
    };

    typedef enum logic [3:0] {
        ST_IDLE = 4'h0,
        ST_RAS = 4'h1,
        ST_COL = 4'h3,
        ST_CAS = 4'h2,
        ST_XFER = 4'h6,
        ST_PAGE = 4'h7,
        ST_PRE = 4'h5,
        ST_REF_CAS = 4'h4,
        ST_REF_RAS = 4'hc,
        ST_PWRUP = 4'h8
    } adfpt_state_t;

endpackage
